/* File: bench/temp_result_and_id_regs_tb.sv */
/*
 * Self-checking bench for the result and identification registers.
 * Assumes the design package and the host model are compiled first.
 */
`default_nettype none

module temp_result_and_id_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import trid_pkg::*;

	localparam logic [15:0] MAKER = 16'h6B2E; // arbitrary value
	localparam logic [7:0]  PART  = 8'h3C;    // arbitrary value
	localparam logic [7:0]  REV   = 8'h02;    // arbitrary value

	logic          core_clk, srst, convDone, wrEn, ptrHit, wrRejected, hit, rej;
	logic [7:0]    regPtr;
	trid_temp_type sampleTemp;
	trid_hyst_type hystSel;
	trid_word_type upperLimitReg, lowerLimitReg, critLimitReg, rdData, measuredTemp, d, ew;
	int            fail_count, n_tests, cycles, seed, mc, mu, ml, lc, lu, ll, hh, i, h;
	int            hs[4] = '{0, 12, 24, 48};
	int            seq[11];

	trid_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION_CODE(REV)) u_trid_regs (
		.core_clk(core_clk), .srst(srst), .sampleTemp(sampleTemp), .convDone(convDone),
		.upperLimitReg(upperLimitReg), .lowerLimitReg(lowerLimitReg),
		.critLimitReg(critLimitReg), .hystSel(hystSel), .regPtr(regPtr), .wrEn(wrEn),
		.rdData(rdData), .ptrHit(ptrHit), .wrRejected(wrRejected),
		.measuredTemp(measuredTemp)
	);

	trid_host_model u_trid_host_model (
		.core_clk(core_clk), .rdData(rdData), .ptrHit(ptrHit),
		.wrRejected(wrRejected), .regPtr(regPtr), .wrEn(wrEn)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task print_verdict;
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			$display("[ERR] %0t run did not finish", $time);
			print_verdict;
		end
	end

	task chk(input trid_word_type got, input trid_word_type exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task setlim(input int c, input int u, input int l, input int hv);
		lc = c;
		lu = u;
		ll = l;
		hh = hs[hv];
		critLimitReg  = {3'h0, c[11:0], 1'b0};
		upperLimitReg = {3'h0, u[11:0], 1'b0};
		lowerLimitReg = {3'h0, l[11:0], 1'b0};
		hystSel       = trid_hyst_type'(hv[1:0]);
	endtask

	// one conversion; convDone stays high when more follow back to back
	task conv(input int tv, input bit last);
		sampleTemp = tv[11:0];
		convDone   = 1'b1;
		@(negedge core_clk);
		mc = (tv >= lc || (mc != 0 && tv > lc - hh)) ? 1 : 0;
		mu = (tv > lu || (mu != 0 && tv > lu - hh)) ? 1 : 0;
		ml = (tv < ll) ? 1 : 0;
		ew = {mc[0], mu[0], ml[0], tv[11:0], 1'b0};
		chk(measuredTemp, ew);
		if (last) begin
			convDone = 1'b0;
		end
	endtask

	initial begin
		seed = 82;
		srst = 1'b1;
		convDone = 1'b0;
		sampleTemp = 12'h000;
		setlim(0, 0, 0, 0);
		repeat (6) @(negedge core_clk);
		srst = 1'b0;
		for (i = 4; i < 9; i++) begin
			u_trid_host_model.rd(i[7:0], d, hit);
			chk(d, i == 6 ? MAKER : i == 7 ? {PART, REV} : 16'h0000);
			chk({15'h0, hit}, {15'h0, i > 4 && i < 8});
		end
		for (h = 0; h < 4; h++) begin
			setlim(640, 480, -80, h);
			seq = '{-81, -80, 0, 481, 481 - hh, 480 - hh, 640, 641 - hh, 640 - hh, 639, -2048};
			for (i = 0; i < 11; i++) begin
				conv(seq[i], i == 10);
			end
			u_trid_host_model.rd(8'h05, d, hit);
			chk(d, ew);
		end
		for (i = 0; i < 200; i++) begin
			if (i % 50 == 0) begin
				setlim($random(seed) % 2048, $random(seed) % 2048, $random(seed) % 2048, i / 50);
			end
			conv($random(seed) % 2048, 1'b1);
			u_trid_host_model.rd(8'h05, d, hit);
			chk(d, ew);
		end
		for (i = 5; i < 8; i++) begin
			u_trid_host_model.wr(i[7:0], rej);
			chk({15'h0, rej}, 16'h0001);
			u_trid_host_model.rd(i[7:0], d, hit);
			chk(d, i == 5 ? ew : i == 6 ? MAKER : {PART, REV});
		end
		u_trid_host_model.wr(8'h02, rej);
		chk({15'h0, rej}, 16'h0000);
		srst = 1'b1;
		@(negedge core_clk);
		srst = 1'b0;
		chk(measuredTemp, 16'h0000);
		mc = 0;
		mu = 0;
		ml = 0;
		conv($random(seed) % 2048, 1'b1);
		print_verdict;
	end
endmodule

`default_nettype wire

/* File: bench/trid_host_model.sv */
/*
 * Host-side register access model: drives the pointer and write strobe.
 * Assumes each call starts just after a falling clock edge.
 */
`default_nettype none

module trid_host_model (
	input  wire logic                    core_clk,
	input  wire trid_pkg::trid_word_type rdData,
	input  wire logic                    ptrHit,
	input  wire logic                    wrRejected,
	output var  logic [7:0]              regPtr,
	output var  logic                    wrEn
);
	timeunit 1ns;
	timeprecision 1ps;
	import trid_pkg::*;

	initial begin
		regPtr = 8'h00;
		wrEn   = 1'b0;
	end

	// pointer held across one rising edge, answer taken at the next fall
	task automatic rd(input logic [7:0] p, output trid_word_type d, output logic hit);
		regPtr = p;
		@(negedge core_clk);
		d   = rdData;
		hit = ptrHit;
	endtask

	task automatic wr(input logic [7:0] p, output logic rej);
		regPtr = p;
		wrEn   = 1'b1;
		@(negedge core_clk);
		rej  = wrRejected;
		wrEn = 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: common/trid_defines.svh */
/*
 * Register pointers, field positions, reset values and hysteresis step
 * counts for the temperature result and identification registers.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TRID_DEFINES_SVH
`define TRID_DEFINES_SVH

`define TRID_PTR_MEASURED   8'h05
`define TRID_PTR_MAKER      8'h06
`define TRID_PTR_PART       8'h07

`define TRID_MEAS_RESET     16'h0000
`define TRID_ZERO_WORD      16'h0000
`define TRID_RESERVED_BIT   1'b0

`define TRID_BIT_CRIT       15
`define TRID_BIT_UPPER      14
`define TRID_BIT_LOWER      13
`define TRID_BIT_SIGN       12
`define TRID_TEMP_MSB       12
`define TRID_TEMP_LSB       1
`define TRID_BIT_RESERVED   0
`define TRID_BIT_128C       11
`define TRID_STEPS_128C     13'sh0400

`define TRID_FLAG_CRIT      2
`define TRID_FLAG_UPPER     1
`define TRID_FLAG_LOWER     0

// hysteresis in steps of one eighth of a degree
`define TRID_HYST_STEPS_0P0 13'h0000
`define TRID_HYST_STEPS_1P5 13'h000C
`define TRID_HYST_STEPS_3P0 13'h0018
`define TRID_HYST_STEPS_6P0 13'h0030

`endif

/* File: common/trid_pkg.sv */
/*
 * Types shared by the temperature result and identification registers.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package trid_pkg;
	typedef logic [15:0]        trid_word_type;
	typedef logic signed [11:0] trid_temp_type;
	typedef logic [2:0]         trid_flags_type;
	typedef enum logic [1:0] {
		TRID_HYST_0P0,
		TRID_HYST_1P5,
		TRID_HYST_3P0,
		TRID_HYST_6P0
	} trid_hyst_type;
endpackage

`default_nettype wire

/* File: verilog/trid_flag_eval.sv */
/*
 * Combinational trip-flag evaluation from one temperature sample, the three
 * thresholds, the hysteresis setting and the flags held so far.
 * Assumes all settings are 12-bit two's complement, eighth-degree steps.
 */
`default_nettype none
`include "trid_defines.svh"

module trid_flag_eval (
	input  wire trid_pkg::trid_temp_type  tempValue,
	input  wire trid_pkg::trid_temp_type  critSetting,
	input  wire trid_pkg::trid_temp_type  upperSetting,
	input  wire trid_pkg::trid_temp_type  lowerSetting,
	input  wire trid_pkg::trid_hyst_type  hystSel,
	input  wire trid_pkg::trid_flags_type prevFlags,
	output var  trid_pkg::trid_flags_type nextFlags
);
	import trid_pkg::*;

	logic signed [12:0] tempExt;
	logic signed [12:0] critExt;
	logic signed [12:0] upperExt;
	logic signed [12:0] lowerExt;
	logic signed [12:0] hystAmount;
	logic signed [12:0] critFloor;
	logic signed [12:0] upperFloor;

	always_comb begin
		tempExt  = {tempValue[11], tempValue};
		critExt  = {critSetting[11], critSetting};
		upperExt = {upperSetting[11], upperSetting};
		lowerExt = {lowerSetting[11], lowerSetting};
		case (hystSel)
			TRID_HYST_0P0: hystAmount = `TRID_HYST_STEPS_0P0;
			TRID_HYST_1P5: hystAmount = `TRID_HYST_STEPS_1P5;
			TRID_HYST_3P0: hystAmount = `TRID_HYST_STEPS_3P0;
			TRID_HYST_6P0: hystAmount = `TRID_HYST_STEPS_6P0;
			default:       hystAmount = `TRID_HYST_STEPS_0P0;
		endcase
		critFloor  = critExt - hystAmount;
		upperFloor = upperExt - hystAmount;
		// crit set at threshold, upper set above it; held until at or below threshold minus hysteresis
		nextFlags[`TRID_FLAG_CRIT] = (tempExt >= critExt)
			|| (prevFlags[`TRID_FLAG_CRIT] && (tempExt > critFloor));
		nextFlags[`TRID_FLAG_UPPER] = (tempExt > upperExt)
			|| (prevFlags[`TRID_FLAG_UPPER] && (tempExt > upperFloor));
		// no hysteresis on the low side
		nextFlags[`TRID_FLAG_LOWER] = (tempExt < lowerExt);
	end
endmodule

`default_nettype wire

/* File: verilog/trid_regs.sv */
/*
 * Measured-temperature, maker-code and part-code/revision registers of a
 * temperature sensor, read through the register pointer.
 * Assumes a conversion engine that pulses convDone with a valid sample, and
 * threshold and hysteresis settings held stable by the configuration logic.
 */
`default_nettype none
`include "trid_defines.svh"

module trid_regs #(
	parameter logic [15:0] MAKER_CODE    = 16'hA5C3, // arbitrary value
	parameter logic [7:0]  PART_CODE     = 8'h5A,    // arbitrary value
	parameter logic [7:0]  REVISION_CODE = 8'h01     // arbitrary value
) (
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	input  wire trid_pkg::trid_temp_type sampleTemp,
	input  wire logic                    convDone,
	input  wire trid_pkg::trid_word_type upperLimitReg,
	input  wire trid_pkg::trid_word_type lowerLimitReg,
	input  wire trid_pkg::trid_word_type critLimitReg,
	input  wire trid_pkg::trid_hyst_type hystSel,
	input  wire logic [7:0]              regPtr,
	input  wire logic                    wrEn,
	output var  trid_pkg::trid_word_type rdData,
	output var  logic                    ptrHit,
	output var  logic                    wrRejected,
	output var  trid_pkg::trid_word_type measuredTemp
);
	import trid_pkg::*;

	trid_temp_type  upperThresholdBits;
	trid_temp_type  lowerThresholdBits;
	trid_temp_type  criticalThresholdBits;
	trid_flags_type heldFlags;
	trid_flags_type next_flags;
	trid_word_type  next_measured;
	trid_word_type  next_rdData;
	trid_word_type  partWord;
	logic           ptrIsOurs;

	// thresholds taken from bits 12..1 of each limit word
	assign upperThresholdBits    = upperLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB];
	assign lowerThresholdBits    = lowerLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB];
	assign criticalThresholdBits = critLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB];

	assign heldFlags = {measuredTemp[`TRID_BIT_CRIT], measuredTemp[`TRID_BIT_UPPER],
		measuredTemp[`TRID_BIT_LOWER]};

	// flags see only the sample, settings and held flags, no event-pin state
	trid_flag_eval u_trid_flag_eval (
		.tempValue    (sampleTemp),
		.critSetting  (criticalThresholdBits),
		.upperSetting (upperThresholdBits),
		.lowerSetting (lowerThresholdBits),
		.hystSel      (hystSel),
		.prevFlags    (heldFlags),
		.nextFlags    (next_flags)
	);

	// same bit layout as the limit words, so compare is direct
	always_comb begin
		next_measured = {next_flags, sampleTemp, `TRID_RESERVED_BIT};
	end

	// whole word replaced in one edge after a conversion
	always_ff @(posedge core_clk) begin
		if (srst) begin
			measuredTemp <= `TRID_MEAS_RESET;
		end else if (convDone) begin
			measuredTemp <= next_measured;
		end
	end

	assign partWord  = {PART_CODE, REVISION_CODE};
	assign ptrIsOurs = (regPtr == `TRID_PTR_MEASURED) || (regPtr == `TRID_PTR_MAKER)
		|| (regPtr == `TRID_PTR_PART);

	always_comb begin
		case (regPtr)
			`TRID_PTR_MEASURED: next_rdData = measuredTemp;
			`TRID_PTR_MAKER:    next_rdData = MAKER_CODE;
			`TRID_PTR_PART:     next_rdData = partWord;
			default:            next_rdData = `TRID_ZERO_WORD;
		endcase
	end

	// read word registered so the bus side never sees a torn value
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdData <= `TRID_ZERO_WORD;
			ptrHit <= 1'b0;
		end else begin
			rdData <= next_rdData;
			ptrHit <= ptrIsOurs;
		end
	end

	// writes here change nothing, only reported
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wrRejected <= 1'b0;
		end else begin
			wrRejected <= wrEn && ptrIsOurs;
		end
	end

	// checking helpers, an independent model of the thresholds
	logic signed [12:0] chkTemp;
	logic signed [12:0] chkCrit;
	logic signed [12:0] chkUpper;
	logic signed [12:0] chkLower;
	logic signed [12:0] chkHyst;
	logic signed [12:0] chkCritFloor;
	logic signed [12:0] chkUpperFloor;

	always_comb begin
		chkTemp  = {sampleTemp[11], sampleTemp};
		chkCrit  = {critLimitReg[`TRID_TEMP_MSB], critLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB]};
		chkUpper = {upperLimitReg[`TRID_TEMP_MSB],
			upperLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB]};
		chkLower = {lowerLimitReg[`TRID_TEMP_MSB],
			lowerLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB]};
		case (hystSel)
			TRID_HYST_0P0: chkHyst = `TRID_HYST_STEPS_0P0;
			TRID_HYST_1P5: chkHyst = `TRID_HYST_STEPS_1P5;
			TRID_HYST_3P0: chkHyst = `TRID_HYST_STEPS_3P0;
			TRID_HYST_6P0: chkHyst = `TRID_HYST_STEPS_6P0;
			default:       chkHyst = `TRID_HYST_STEPS_0P0;
		endcase
		chkCritFloor  = chkCrit - chkHyst;
		chkUpperFloor = chkUpper - chkHyst;
	end

	sequence s_conv;
		convDone;
	endsequence

	sequence s_critHot;
		convDone && (chkTemp >= chkCrit);
	endsequence

	sequence s_critCool;
		convDone && (chkTemp <= chkCritFloor);
	endsequence

	sequence s_critBand;
		convDone && measuredTemp[`TRID_BIT_CRIT] && (chkTemp > chkCritFloor);
	endsequence

	property p_capture;
		trid_temp_type t;
		@(posedge core_clk) disable iff (srst)
		(s_conv, t = sampleTemp) |=> (measuredTemp[`TRID_TEMP_MSB:`TRID_TEMP_LSB] == t)
			&& (measuredTemp[`TRID_BIT_SIGN] == (t < 0));
	endproperty
	a_capture: assert property (p_capture) else $error("measured value not captured");

	property p_sign;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp < 0) |=> measuredTemp[`TRID_BIT_SIGN];
	endproperty
	a_sign: assert property (p_sign) else $error("sign bit wrong for negative");

	property p_reserved;
		@(posedge core_clk) disable iff (srst)
		s_conv ##1 1'b1 |-> (measuredTemp[`TRID_BIT_RESERVED] == 1'b0) [*2];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit not zero");

	property p_critSet;
		@(posedge core_clk) disable iff (srst)
		s_critHot |=> measuredTemp[`TRID_BIT_CRIT];
	endproperty
	a_critSet: assert property (p_critSet) else $error("critical flag not set");

	property p_critHold;
		@(posedge core_clk) disable iff (srst)
		s_critBand |=> measuredTemp[`TRID_BIT_CRIT];
	endproperty
	a_critHold: assert property (p_critHold) else $error("critical flag dropped early");

	property p_critClear;
		@(posedge core_clk) disable iff (srst)
		s_critCool and (convDone && (chkTemp < chkCrit)) |=> !measuredTemp[`TRID_BIT_CRIT];
	endproperty
	a_critClear: assert property (p_critClear) else $error("critical flag stuck");

	property p_upperSet;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp > chkUpper) |=> measuredTemp[`TRID_BIT_UPPER];
	endproperty
	a_upperSet: assert property (p_upperSet) else $error("upper flag not set");

	property p_upperClear;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp <= chkUpperFloor) |=> !measuredTemp[`TRID_BIT_UPPER];
	endproperty
	a_upperClear: assert property (p_upperClear) else $error("upper flag stuck");

	property p_lower;
		@(posedge core_clk) disable iff (srst)
		convDone |=> measuredTemp[`TRID_BIT_LOWER] == $past(chkTemp < chkLower);
	endproperty
	a_lower: assert property (p_lower) else $error("lower flag wrong");

	property p_hold;
		@(posedge core_clk) disable iff (srst)
		!convDone |=> $stable(measuredTemp);
	endproperty
	a_hold: assert property (p_hold) else $error("measured word changed without conversion");

	sequence s_readMeas;
		regPtr == `TRID_PTR_MEASURED;
	endsequence

	property p_readMeas;
		@(posedge core_clk) disable iff (srst)
		s_readMeas |=> rdData == $past(measuredTemp) && ptrHit;
	endproperty
	a_readMeas: assert property (p_readMeas) else $error("measured read wrong");

	property p_readMaker;
		@(posedge core_clk) disable iff (srst)
		regPtr == `TRID_PTR_MAKER |=> rdData == MAKER_CODE;
	endproperty
	a_readMaker: assert property (p_readMaker) else $error("maker code read wrong");

	property p_readPart;
		@(posedge core_clk) disable iff (srst)
		regPtr == `TRID_PTR_PART |=> rdData[15:8] == PART_CODE && rdData[7:0] == REVISION_CODE;
	endproperty
	a_readPart: assert property (p_readPart) else $error("part code read wrong");

	property p_writeIgnored;
		@(posedge core_clk) disable iff (srst)
		wrEn && ptrIsOurs && !convDone |=> wrRejected && $stable(measuredTemp);
	endproperty
	a_writeIgnored: assert property (p_writeIgnored) else $error("write not ignored");

	// reset clears every output, checked without the reset disable
	property p_reset;
		@(posedge core_clk)
		srst |=> (measuredTemp == `TRID_MEAS_RESET) && (rdData == `TRID_ZERO_WORD)
			&& !ptrHit && !wrRejected;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");

	property p_critQuiet;
		@(posedge core_clk) disable iff (srst)
		convDone && !measuredTemp[`TRID_BIT_CRIT] && (chkTemp < chkCrit) |=> !measuredTemp[`TRID_BIT_CRIT];
	endproperty
	a_critQuiet: assert property (p_critQuiet) else $error("critical flag set below");

	property p_upperHold;
		@(posedge core_clk) disable iff (srst)
		convDone && measuredTemp[`TRID_BIT_UPPER] && (chkTemp > chkUpperFloor)
			|=> measuredTemp[`TRID_BIT_UPPER];
	endproperty
	a_upperHold: assert property (p_upperHold) else $error("upper flag dropped early");

	property p_upperQuiet;
		@(posedge core_clk) disable iff (srst)
		convDone && !measuredTemp[`TRID_BIT_UPPER] && (chkTemp <= chkUpper)
			|=> !measuredTemp[`TRID_BIT_UPPER];
	endproperty
	a_upperQuiet: assert property (p_upperQuiet) else $error("upper flag set at limit");

	property p_lowerClear;
		@(posedge core_clk) disable iff (srst)
		convDone && measuredTemp[`TRID_BIT_LOWER] && (chkTemp >= chkLower)
			|=> !measuredTemp[`TRID_BIT_LOWER];
	endproperty
	a_lowerClear: assert property (p_lowerClear) else $error("lower flag kept");

	// sample equal to the upper or critical limit must show that limit's own bits
	property p_upperEncoding;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp == chkUpper) |=> measuredTemp[`TRID_TEMP_MSB:`TRID_TEMP_LSB]
			== $past(upperLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB]);
	endproperty
	a_upperEncoding: assert property (p_upperEncoding) else $error("encoding differs");

	property p_critEncoding;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp == chkCrit) |=> measuredTemp[`TRID_BIT_CRIT]
			&& (measuredTemp[`TRID_TEMP_MSB:`TRID_TEMP_LSB]
			== $past(critLimitReg[`TRID_TEMP_MSB:`TRID_TEMP_LSB]));
	endproperty
	a_critEncoding: assert property (p_critEncoding) else $error("critical bits misread");

	sequence s_noneHeld;
		convDone && !measuredTemp[`TRID_BIT_CRIT] && !measuredTemp[`TRID_BIT_UPPER];
	endsequence

	// with nothing held the flags are plain temperature compares
	property p_flagsFromTemp;
		@(posedge core_clk) disable iff (srst)
		s_noneHeld |=> measuredTemp[`TRID_BIT_CRIT:`TRID_BIT_LOWER]
			== $past({chkTemp >= chkCrit, chkTemp > chkUpper, chkTemp < chkLower});
	endproperty
	a_flagsFromTemp: assert property (p_flagsFromTemp) else $error("flags not from temp");

	property p_signPos;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp >= 0) |=> !measuredTemp[`TRID_BIT_SIGN];
	endproperty
	a_signPos: assert property (p_signPos) else $error("sign bit wrong for positive");

	property p_weight;
		@(posedge core_clk) disable iff (srst)
		convDone && (chkTemp >= `TRID_STEPS_128C) |=> measuredTemp[`TRID_BIT_128C];
	endproperty
	a_weight: assert property (p_weight) else $error("top value bit weight wrong");

	property p_readReserved;
		@(posedge core_clk) disable iff (srst)
		s_readMeas |=> !rdData[`TRID_BIT_RESERVED];
	endproperty
	a_readReserved: assert property (p_readReserved) else $error("reserved bit read set");

	property p_readOther;
		@(posedge core_clk) disable iff (srst)
		!ptrIsOurs |=> (rdData == `TRID_ZERO_WORD) && !ptrHit;
	endproperty
	a_readOther: assert property (p_readOther) else $error("foreign pointer answered");

	property p_hitMaker;
		@(posedge core_clk) disable iff (srst)
		regPtr == `TRID_PTR_MAKER |=> ptrHit;
	endproperty
	a_hitMaker: assert property (p_hitMaker) else $error("maker pointer not hit");

	property p_hitPart;
		@(posedge core_clk) disable iff (srst)
		regPtr == `TRID_PTR_PART |=> ptrHit;
	endproperty
	a_hitPart: assert property (p_hitPart) else $error("part pointer not hit");

	property p_noReject;
		@(posedge core_clk) disable iff (srst)
		!(wrEn && ptrIsOurs) |=> !wrRejected;
	endproperty
	a_noReject: assert property (p_noReject) else $error("reject without own write");

endmodule

`default_nettype wire
